/* File: dv/fic_cpu_model.sv */
// CPU core partner model: takes vector calls and issues returns
`timescale 1ns/1ps
`default_nettype none

module fic_cpu_model
    import fic_pkg::*;
(
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          rst,
    // Bench commands
    input  wire logic          go,
    input  wire logic          do_return_from_irq,
    // Controller side
    input  wire fic_req_s      cpu_req,
    output logic               cpu_instr_done,
    output logic               cpu_ack,
    output logic               cpu_return_from_irq,
    // Record of calls taken
    output logic [SLOT_W-1:0]  last_slot,
    output logic [7:0]         n_taken
);
    // Instruction stream: one instruction ends every second cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cpu_instr_done <= 1'b0;
        end else begin
            cpu_instr_done <= !cpu_instr_done;
        end
    end

    // Vector call on request when allowed, return on command
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cpu_ack   <= 1'b0;
            cpu_return_from_irq  <= 1'b0;
            last_slot <= '0;
            n_taken   <= 8'h00;
        end else begin
            cpu_ack  <= go && cpu_req.valid && !cpu_ack && !do_return_from_irq;
            cpu_return_from_irq <= do_return_from_irq;
            if (cpu_ack && cpu_req.valid) begin
                last_slot <= cpu_req.slot;
                n_taken   <= n_taken + 8'h01;
            end
        end
    end
endmodule

`default_nettype wire

/* File: dv/fic_ctrl_monitor.sv */
// Port checker for the interrupt controller, bound to the top module
`timescale 1ns/1ps
`default_nettype none

module fic_ctrl_monitor
    import fic_pkg::*;
(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // APB
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [31:0]      prdata,
    input  wire logic             pready,
    input  wire logic             pslverr,
    // Sources and CPU side
    input  wire logic [NSLOT-1:0] src_event,
    input  wire logic             cpu_instr_done,
    input  wire logic             cpu_ack,
    input  wire logic             cpu_return_from_irq,
    input  wire fic_req_s         cpu_req,
    input  wire logic             irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Bus timing and data
    // ------------------------------------------------------------
    property p_wait_state;
        psel && !penable |=> pready;
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("pready late after setup");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
    property p_err_zero;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error without ready or with data");
    property p_idle_zero;
        !pready |-> prdata == 32'h0 && !pslverr;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("bus outputs active while idle");

    // ------------------------------------------------------------
    // Vector request
    // ------------------------------------------------------------
    property p_vector;
        cpu_req.valid |-> cpu_req.vector[2:0] == 3'h3 && cpu_req.vector[15:3] == 13'(cpu_req.slot);
    endproperty
    a_vector: assert property (p_vector) else $error("vector address wrong");
    property p_slot_ok;
        cpu_req.valid |-> SLOT_VALID[cpu_req.slot];
    endproperty
    a_slot_ok: assert property (p_slot_ok) else $error("request for reserved slot");
    property p_ack_drop;
        cpu_req.valid && cpu_ack |=> !cpu_req.valid;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("request held after call");
    property p_return_from_irq_drop;
        cpu_return_from_irq |=> !cpu_req.valid;
    endproperty
    a_return_from_irq_drop: assert property (p_return_from_irq_drop) else $error("request in return cycle");
    property p_return_from_irq_wait;
        cpu_return_from_irq ##1 !cpu_instr_done |=> !cpu_req.valid;
    endproperty
    a_return_from_irq_wait: assert property (p_return_from_irq_wait) else $error("reentry before next instruction");

    // Main scenarios reached
    c_call: cover property (cpu_req.valid && cpu_ack);
    c_ret: cover property (cpu_return_from_irq);
    c_err: cover property (pslverr);
    c_irq: cover property ($rose(irq));
endmodule

bind fic_ctrl fic_ctrl_monitor mon (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .src_event, .cpu_instr_done, .cpu_ack, .cpu_return_from_irq, .cpu_req, .irq);

`default_nettype wire

/* File: dv/test_fic_ctrl.sv */
// Self-checking bench for the four-level interrupt controller
`timescale 1ns/1ps
`default_nettype none

module test_fic_ctrl
    import fic_pkg::*;
;
    logic                 core_clk;
    logic                 rst = 1'b1;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [7:0]           paddr = 8'h00;
    logic [31:0]          pwdata = 32'h0;
    logic [NSLOT-1:0]     src_event = '0;
    logic                 go = 1'b0;
    logic                 do_return_from_irq = 1'b0;
    logic [31:0]          prdata, q;
    logic                 pready, pslverr, irq, e;
    logic                 cpu_instr_done, cpu_ack, cpu_return_from_irq;
    logic [SLOT_W-1:0]    last_slot;
    logic [7:0]           n_taken;
    fic_req_s             cpu_req;
    logic [15:0]          last_vec;
    logic [LVL_W-1:0]     last_lvl;
    int                   fail_count = 0;
    int                   checks_done = 0;
    int                   cyc = 0;

    fic_ctrl uut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .src_event, .cpu_instr_done, .cpu_ack, .cpu_return_from_irq, .cpu_req, .irq);
    fic_cpu_model cpu (.core_clk, .rst, .go, .do_return_from_irq, .cpu_req, .cpu_instr_done, .cpu_ack,
        .cpu_return_from_irq, .last_slot, .n_taken);

    // Clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fail_count++;
            conclude();
        end
    end

    // Record what each vector call carried
    always @(posedge core_clk) begin
        if (cpu_ack === 1'b1 && cpu_req.valid === 1'b1) begin
            last_vec <= cpu_req.vector;
            last_lvl <= cpu_req.level;
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic take(input logic [SLOT_W-1:0] s, input logic [LVL_W-1:0] l = '0);
        logic [7:0] n0;
        n0 = n_taken;
        go <= 1'b1;
        repeat (40) if (n_taken === n0) @(posedge core_clk);
        go <= 1'b0;
        chk("calls", 32'(n0 + 8'h01), 32'(n_taken));
        chk("slot", 32'(s), 32'(last_slot));
        chk("vector", 32'h3 + 32'(s) * 32'h8, 32'(last_vec));
        chk("level", 32'(l), 32'(last_lvl));
    endtask
    task automatic none_taken;
        logic [7:0] n0;
        n0 = n_taken;
        go <= 1'b1;
        repeat (20) @(posedge core_clk);
        go <= 1'b0;
        chk("no call", 32'(n0), 32'(n_taken));
    endtask
    task automatic return_from_irq;
        do_return_from_irq <= 1'b1;
        @(posedge core_clk);
        do_return_from_irq <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic conclude;
        if (fail_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        for (int a = 0; a <= 'h30; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            chk("reset value", 32'h0, q);
        end
        apb(1'b0, 8'h34, 32'h0);
        chk("unmapped", 32'h1, 32'(e));
    endtask
    task automatic t_basic;
        apb(1'b1, OFS_EN_A, 32'h84);
        src_event <= 19'h00004;
        @(posedge core_clk);
        src_event <= '0;
        take(5'h2);
        apb(1'b0, OFS_PEND, 32'h0);
        chk("hw cleared", 32'h0, q);
        chk("irq masked", 32'h0, 32'(irq));
        apb(1'b1, OFS_EVT_MASK, 32'h1);
        apb(1'b0, OFS_ACTIVE, 32'h0);
        chk("active", 32'h1, q);
        chk("irq", 32'h1, 32'(irq));
        apb(1'b1, OFS_EVT_STAT, 32'h7);
        apb(1'b0, OFS_EVT_STAT, 32'h0);
        chk("irq cleared", 32'h0, 32'(irq) | q);
        return_from_irq();
    endtask
    task automatic t_gate;
        apb(1'b1, OFS_EN_A, 32'h10);
        src_event <= 19'h00010;
        @(posedge core_clk);
        src_event <= '0;
        apb(1'b0, OFS_PEND, 32'h0);
        chk("pending", 32'h10, q);
        none_taken();
        apb(1'b1, OFS_EN_A, 32'h90);
        apb(1'b1, OFS_EN_A, 32'h10);
        chk("req in clear window", 32'h1, 32'(cpu_req.valid));
        @(posedge core_clk);
        chk("req after clear", 32'h0, 32'(cpu_req.valid));
        apb(1'b1, OFS_EN_A, 32'h90);
        take(5'h4);
        return_from_irq();
        take(5'h4);
        apb(1'b1, OFS_PEND, 32'h0);
        return_from_irq();
        none_taken();
    endtask
    task automatic t_prio;
        apb(1'b1, OFS_EN_A, 32'hF0);
        apb(1'b1, OFS_PLO_A, 32'h50);
        apb(1'b1, OFS_PHI_A, 32'h60);
        apb(1'b1, OFS_PEND, 32'h70);
        take(5'h6, 2'h3);
        none_taken();
        apb(1'b1, OFS_PEND, 32'h30);
        return_from_irq();
        take(5'h5, 2'h2);
        apb(1'b1, OFS_PEND, 32'h10);
        return_from_irq();
        take(5'h4, 2'h1);
        apb(1'b1, OFS_PEND, 32'h0);
        return_from_irq();
    endtask
    task automatic t_nest;
        apb(1'b1, OFS_PLO_A, 32'h0);
        apb(1'b1, OFS_PHI_A, 32'h40);
        apb(1'b1, OFS_PEND, 32'h30);
        take(5'h4);
        apb(1'b1, OFS_PEND, 32'h60);
        take(5'h6, 2'h2);
        apb(1'b0, OFS_EVT_STAT, 32'h0);
        chk("events", 32'h7, q);
        apb(1'b0, OFS_ACTIVE, 32'h0);
        chk("nested active", 32'h5, q);
        apb(1'b1, OFS_PEND, 32'h20);
        return_from_irq();
        none_taken();
        apb(1'b1, OFS_PEND, 32'h0);
        return_from_irq();
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_basic();
        t_gate();
        t_prio();
        t_nest();
        conclude();
    end
endmodule

`default_nettype wire

/* File: hw/fic_ctrl.sv */
// Four-level interrupt controller with APB registers and CPU vector request
//
// Overview of operation
// - Source event sets its pending flag
// - Flags set even while source is disabled
// - Enabled pending flag raises a vector request
// - Return resumes interrupted code; routines end so
// - Per-source enables count only under global enable
// - Global enable low blocks every source
// - Enable clear lands one cycle after detect
// - Some flags cleared on vector, others by software
// - Still-pending flag re-requests after one instruction
// - Eighteen sources; software write of one triggers
// - Two priority bits per source in register pairs
// - Level decode: high bit then low bit
// - Only strictly higher level preempts; top never
// - Highest level first, ties by slot order
// - Reset puts every source at lowest level
// - Requests sampled and decoded every clock
// - On exit serve highest pending request next
`timescale 1ns/1ps
`default_nettype none

module fic_ctrl
    import fic_pkg::*;
(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Peripheral flag sources
    input  wire logic [NSLOT-1:0] src_event,
    // CPU core side
    input  wire logic             cpu_instr_done,
    input  wire logic             cpu_ack,
    input  wire logic             cpu_return_from_irq,
    output fic_req_s              cpu_req,
    // Controller interrupt
    output logic                  irq
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [REG_W-1:0] en_a_ff, en_b_ff, en_c_ff;
    logic [REG_W-1:0] plo_a_ff, plo_b_ff, plo_c_ff;
    logic [REG_W-1:0] phi_a_ff, phi_b_ff, phi_c_ff;
    logic [NSLOT-1:0] pend_ff;
    logic [NSLOT-1:0] nxt_pend;
    logic [NLVL-1:0]  active_ff;
    logic [EVT_W-1:0] evt_stat_ff, evt_mask_ff;
    logic [EVT_W-1:0] evt_now;
    logic [31:0]      prdata_ff;
    logic             pready_ff;
    logic             pslverr_ff;
    logic             irq_ff;
    fic_req_s         req_ff;
    fic_req_s         nxt_req;
    fic_ctl_e         ctl_ff;
    fic_apb_s         bus;

    // Decode and arbitration wires
    logic             wr_go;
    logic             addr_hit;
    logic [31:0]      rd_val;
    logic [NSLOT-1:0] en_vec, plo_vec, phi_vec, cand;
    logic [NSLOT-1:0][LVL_W-1:0] slot_lvl;
    logic             glb_en;
    logic [LVL_W-1:0] cur_lvl;
    logic             any_active;
    logic [LVL_W-1:0] best_lvl;
    logic [SLOT_W-1:0] best_slot;
    logic             best_ok;
    logic             take_new;

    assign bus = '{sel: psel, en: penable, wr: pwrite, addr: paddr, wdata: pwdata};

    // Write lands at the completing access edge only
    // A setup cycle alone never changes a register
    // A read changes nothing; pending and status writes are decoded below
    assign wr_go = bus.sel & bus.en & pready_ff & bus.wr;

    // ------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------
    // Unmapped offsets read zero and raise the error flag
    // Narrow registers return their value in the low bits, upper bits zero
    always_comb begin
        addr_hit = 1'b1;
        rd_val = '0;
        case (bus.addr)
            OFS_EN_A:     rd_val[REG_W-1:0] = en_a_ff;
            OFS_EN_B:     rd_val[REG_W-1:0] = en_b_ff;
            OFS_EN_C:     rd_val[REG_W-1:0] = en_c_ff;
            OFS_PLO_A:    rd_val[REG_W-1:0] = plo_a_ff;
            OFS_PLO_B:    rd_val[REG_W-1:0] = plo_b_ff;
            OFS_PLO_C:    rd_val[REG_W-1:0] = plo_c_ff;
            OFS_PHI_A:    rd_val[REG_W-1:0] = phi_a_ff;
            OFS_PHI_B:    rd_val[REG_W-1:0] = phi_b_ff;
            OFS_PHI_C:    rd_val[REG_W-1:0] = phi_c_ff;
            OFS_PEND:     rd_val[NSLOT-1:0] = pend_ff;
            OFS_ACTIVE:   rd_val[NLVL-1:0] = active_ff;
            OFS_EVT_STAT: rd_val[EVT_W-1:0] = evt_stat_ff;
            OFS_EVT_MASK: rd_val[EVT_W-1:0] = evt_mask_ff;
            default:      addr_hit = 1'b0;
        endcase
    end

    // APB answer: no wait states, registered outputs
    // Data and error are zero outside the access cycle, so nothing stale shows
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready_ff <= 1'b0;
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end else if (bus.sel & ~bus.en) begin
            pready_ff <= 1'b1;
            prdata_ff <= bus.wr ? 32'h0000_0000 : rd_val;
            pslverr_ff <= ~addr_hit;
        end else begin
            pready_ff <= 1'b0;
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Enable and priority registers
    // ------------------------------------------------------------
    // All priority bits clear at reset: every source at level 0
    // Writes to read-only or unmapped offsets change nothing
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // Global enable and every slot enable start off
            en_a_ff <= REG_RST;
            en_b_ff <= REG_RST;
            en_c_ff <= REG_RST;
            plo_a_ff <= REG_RST;
            plo_b_ff <= REG_RST;
            plo_c_ff <= REG_RST;
            phi_a_ff <= REG_RST;
            phi_b_ff <= REG_RST;
            phi_c_ff <= REG_RST;
            evt_mask_ff <= '0;
        end else if (wr_go) begin
            case (bus.addr)
                OFS_EN_A:     en_a_ff <= bus.wdata[REG_W-1:0];
                OFS_EN_B:     en_b_ff <= bus.wdata[REG_W-1:0];
                OFS_EN_C:     en_c_ff <= bus.wdata[REG_W-1:0];
                OFS_PLO_A:    plo_a_ff <= bus.wdata[REG_W-1:0];
                OFS_PLO_B:    plo_b_ff <= bus.wdata[REG_W-1:0];
                OFS_PLO_C:    plo_c_ff <= bus.wdata[REG_W-1:0];
                OFS_PHI_A:    phi_a_ff <= bus.wdata[REG_W-1:0];
                OFS_PHI_B:    phi_b_ff <= bus.wdata[REG_W-1:0];
                OFS_PHI_C:    phi_c_ff <= bus.wdata[REG_W-1:0];
                OFS_EVT_MASK: evt_mask_ff <= bus.wdata[EVT_W-1:0];
                default:      ;
            endcase
        end
    end

    // Per-slot views of the spread register bits
    // Register a carries slots 0-6 below its global bit, register c only four
    assign en_vec = {en_c_ff[C_SLOTS-1:0], en_b_ff[B_SLOTS-1:0], en_a_ff[A_SLOTS-1:0]};
    assign plo_vec = {plo_c_ff[C_SLOTS-1:0], plo_b_ff[B_SLOTS-1:0], plo_a_ff[A_SLOTS-1:0]};
    assign phi_vec = {phi_c_ff[C_SLOTS-1:0], phi_b_ff[B_SLOTS-1:0], phi_a_ff[A_SLOTS-1:0]};

    // Global gate: while it is low no slot can become a candidate
    assign glb_en = en_a_ff[GLOBAL_EN_BIT];

    // ------------------------------------------------------------
    // Per-slot lanes
    // ------------------------------------------------------------
    // Each lane decodes its level and gates its flag; the flag of a
    // disabled slot stays stored but never becomes a candidate
    for (genvar gi = 0; gi < NSLOT; gi++) begin : g_slot
        assign slot_lvl[gi] = {phi_vec[gi], plo_vec[gi]};
        assign cand[gi] = pend_ff[gi] & en_vec[gi] & SLOT_VALID[gi] & glb_en;
    end

    // ------------------------------------------------------------
    // Pending flags
    // ------------------------------------------------------------
    // Hardware set wins over a software clear in the same cycle
    always_comb begin
        nxt_pend = pend_ff;
        // Software write first, then hardware clear, then new events on top
        if (wr_go && bus.addr == OFS_PEND)
            nxt_pend = bus.wdata[NSLOT-1:0];
        if (cpu_ack && req_ff.valid && HW_CLR_MASK[req_ff.slot])
            nxt_pend[req_ff.slot] = 1'b0;
        nxt_pend = (nxt_pend | src_event) & SLOT_VALID;
    end

    // Pending store: one flag per slot, reserved slot held at zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            pend_ff <= '0;
        else
            pend_ff <= nxt_pend;
    end

    // ------------------------------------------------------------
    // Priority resolve
    // ------------------------------------------------------------
    // Highest level wins; lower slot number wins a tie
    // Scanning from the top slot down with >= lets the lower slot take a tie
    always_comb begin
        best_ok = 1'b0;
        best_lvl = '0;
        best_slot = '0;
        for (int i = NSLOT - 1; i >= 0; i--) begin
            if (cand[i] && (!best_ok || slot_lvl[i] >= best_lvl)) begin
                best_ok = 1'b1;
                best_lvl = slot_lvl[i];
                best_slot = SLOT_W'(i);
            end
        end
    end

    // Threshold is the highest level still in service
    // One bit per level suffices: only a strictly higher level can nest,
    // so no level is ever entered twice
    always_comb begin
        cur_lvl = '0;
        for (int l = 0; l < NLVL; l++) begin
            if (active_ff[l])
                cur_lvl = LVL_W'(l);
        end
    end

    assign any_active = |active_ff;

    // Strictly higher level preempts; a top-level routine is never preempted
    // A request at the running level waits for the return
    // Level 3 is checked on its own so a top routine is never interrupted
    assign take_new = best_ok && (!any_active || (cur_lvl != LVL_TOP && best_lvl > cur_lvl));

    // ------------------------------------------------------------
    // Sequencing after a return
    // ------------------------------------------------------------
    // After a return one more instruction runs before re-entry
    // Without the gap a flag left set would re-enter before the interrupted
    // code made any progress; a second return inside the gap restarts it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            ctl_ff <= CT_RUN;
        else begin
            case (ctl_ff)
                CT_RUN: if (cpu_return_from_irq) ctl_ff <= CT_GAP;
                CT_GAP: if (cpu_instr_done && !cpu_return_from_irq) ctl_ff <= CT_RUN;
                default: ctl_ff <= CT_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Vector request to the CPU
    // ------------------------------------------------------------
    // Registered decode: one cycle to detect, so an enable clear
    // seen by a single-cycle follower may still vector
    always_comb begin
        nxt_req.valid = take_new && (ctl_ff == CT_RUN) && !cpu_return_from_irq && !cpu_ack;
        nxt_req.slot = best_slot;
        nxt_req.level = best_lvl;
        // Service address: base plus eight bytes per slot
        nxt_req.vector = VEC_BASE + (16'(best_slot) << VEC_STEP_SHIFT);
    end

    // Request register: the CPU takes slot and vector from here on its ack
    // Dropped on ack and on return, so the CPU never sees a stale slot
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            req_ff <= '0;
        else
            req_ff <= nxt_req;
    end

    // ------------------------------------------------------------
    // Nesting tracker
    // ------------------------------------------------------------
    // Push level on vector, pop highest on return
    // A vector and a return in one cycle cannot come from a sane CPU;
    // should they meet, the push is kept and the pop is lost
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            active_ff <= '0;
        else if (cpu_ack && req_ff.valid)
            active_ff[req_ff.level] <= 1'b1;
        else if (cpu_return_from_irq && any_active)
            active_ff[cur_lvl] <= 1'b0;
    end

    // ------------------------------------------------------------
    // Controller events and interrupt line
    // ------------------------------------------------------------
    // Events seen this cycle: vector, return, nested vector
    assign evt_now[EVT_VECTOR] = cpu_ack & req_ff.valid;
    assign evt_now[EVT_RETURN] = cpu_return_from_irq & any_active;
    assign evt_now[EVT_PREEMPT] = cpu_ack & req_ff.valid & any_active;

    // Sticky status, write one to clear, new event wins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            evt_stat_ff <= '0;
        else if (wr_go && bus.addr == OFS_EVT_STAT)
            evt_stat_ff <= (evt_stat_ff & ~bus.wdata[EVT_W-1:0]) | evt_now;
        else
            evt_stat_ff <= evt_stat_ff | evt_now;
    end

    // Level interrupt: high while an unmasked status bit is set, one cycle late
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(evt_stat_ff & evt_mask_ff);
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output comes straight from a register
    // so no decode glitch reaches the bus or the CPU
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign cpu_req = req_ff;
    assign irq = irq_ff;

endmodule

`default_nettype wire

/* File: hw/fic_pkg.sv */
// Package for the four-level interrupt controller: map, layouts, carriers
package fic_pkg;

    // ------------------------------------------------------------
    // Source slots and layout
    // ------------------------------------------------------------
    localparam int NSLOT = 19;                    // Vector slots, one reserved
    localparam int SLOT_W = 5;
    localparam int LVL_W = 2;
    localparam int NLVL = 4;
    localparam int REG_W = 8;
    localparam int A_SLOTS = 7;                   // Slots 0..6 in register a
    localparam int B_SLOTS = 8;                   // Slots 7..14 in register b
    localparam int C_SLOTS = 4;                   // Slots 15..18 in register c
    localparam int GLOBAL_EN_BIT = 7;
    localparam logic [NSLOT-1:0] SLOT_VALID = 19'h7DFFF;  // Slot 13 reserved
    localparam logic [NSLOT-1:0] HW_CLR_MASK = 19'h0000F; // Cleared on vector
    localparam logic [LVL_W-1:0] LVL_TOP = 2'h3;

    // ------------------------------------------------------------
    // Vector addresses
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam int VEC_STEP_SHIFT = 3;            // Vectors spaced by eight bytes

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_EN_A = 8'h00;
    localparam logic [7:0] OFS_EN_B = 8'h04;
    localparam logic [7:0] OFS_EN_C = 8'h08;
    localparam logic [7:0] OFS_PLO_A = 8'h0C;
    localparam logic [7:0] OFS_PLO_B = 8'h10;
    localparam logic [7:0] OFS_PLO_C = 8'h14;
    localparam logic [7:0] OFS_PHI_A = 8'h18;
    localparam logic [7:0] OFS_PHI_B = 8'h1C;
    localparam logic [7:0] OFS_PHI_C = 8'h20;
    localparam logic [7:0] OFS_PEND = 8'h24;
    localparam logic [7:0] OFS_ACTIVE = 8'h28;
    localparam logic [7:0] OFS_EVT_STAT = 8'h2C;
    localparam logic [7:0] OFS_EVT_MASK = 8'h30;
    localparam logic [REG_W-1:0] REG_RST = 8'h00;

    // ------------------------------------------------------------
    // Controller event bits
    // ------------------------------------------------------------
    localparam int EVT_W = 3;
    localparam int EVT_VECTOR = 0;                // Vector call taken
    localparam int EVT_RETURN = 1;                // Return completed
    localparam int EVT_PREEMPT = 2;               // Nested entry taken

    // ------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic              valid;
        logic [SLOT_W-1:0] slot;
        logic [LVL_W-1:0]  level;
        logic [15:0]       vector;
    } fic_req_s;

    typedef struct packed {
        logic        sel;
        logic        en;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } fic_apb_s;

    typedef enum logic [0:0] {CT_RUN, CT_GAP} fic_ctl_e;

endpackage
